// *** timer_ctl_pkg.sv ***
// Function
// - Timer 1 overflow sets bit 7
// - Bit 7 cleared by vector or write-zero
// - Writing 1 to bit 6 runs Timer 1
// - Timer 0 overflow sets bit 5
// - Bit 5 cleared by vector or write-zero
package timer_ctl_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] TIMER_CONTROL_ADDR  = 8'h88; // Special-function address, all pages
  localparam logic [7:0] TIMER_CONTROL_RESET = 8'h00; // Every bit resets to zero
  localparam int         T1_FLAG_BIT         = 7;     // Timer 1 overflow flag
  localparam int         T1_RUN_BIT          = 6;     // Timer 1 run enable
  localparam int         T0_FLAG_BIT         = 5;     // Timer 0 overflow flag
  localparam logic [7:0] SLICE_MASK          = 8'he0; // Bits owned by this slice
  // ==========================================================
  // Timer 1 counter
  localparam int         T1_WIDTH            = 16;    // Timer 1 count width
endpackage

// *** timer1_counter.sv ***
`timescale 1ns/1ps
// ==========================================================
// Timer 1 up-counter, advances only while run is high
module timer1_counter
  import timer_ctl_pkg::*;
#(
  parameter int WIDTH = T1_WIDTH               // Count width
) (
  input  wire logic             sys_clk_in,    // System clock
  input  wire logic             rst_n_in,      // Async reset, active low
  input  wire logic             run_in,        // Count enable
  input  wire logic             tick_in,       // Count pulse
  output logic [WIDTH-1:0]      count_out,     // Current count
  output logic                  overflow_out   // Wrap pulse
);
  logic [WIDTH-1:0] count_r;                   // Count register
  logic             ovf_r;                     // Registered wrap pulse
  wire              step = run_in & tick_in;   // Advance this cycle
  wire              wrap = step & (&count_r);  // All ones rolls over

  // Count holds while stopped
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_r <= '0;
      ovf_r   <= 1'b0;
    end else begin
      if (step) begin
        count_r <= count_r + 1'b1;
      end
      ovf_r <= wrap;
    end
  end

  assign count_out    = count_r;
  assign overflow_out = ovf_r;

  a_hold_stopped: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    !$past(run_in) |-> count_r == $past(count_r))
    else $error("Timer 1 moved while stopped");
endmodule

// *** timer_overflow_run_control.sv ***
`timescale 1ns/1ps
// ==========================================================
// Timer control register slice: two overflow flags, Timer 1 run
module timer_overflow_run_control
  import timer_ctl_pkg::*;
(
  input  wire logic        sys_clk_in,     // 40 MHz system clock
  input  wire logic        rst_n_in,       // Async reset, active low
  input  wire logic [7:0]  sfr_addr_in,    // Special-function address
  input  wire logic        sfr_wr_in,      // Byte write strobe
  input  wire logic        sfr_rd_in,      // Byte read strobe
  input  wire logic [7:0]  sfr_wdata_in,   // Write data
  input  wire logic        bit_wr_in,      // Bit-addressed write strobe
  input  wire logic [2:0]  bit_sel_in,     // Bit number in register
  input  wire logic        bit_val_in,     // Bit write value
  input  wire logic        t1_tick_in,     // Timer 1 count pulse
  input  wire logic        t0_ovf_in,      // Timer 0 overflow pulse
  input  wire logic        t1_vector_in,   // CPU vectors to Timer 1 handler
  input  wire logic        t0_vector_in,   // CPU vectors to Timer 0 handler
  output logic [7:0]       sfr_rdata_out,  // Read data, registered
  output logic             timer1_overflow_flag_out, // Timer 1 flag
  output logic             timer1_run_out,           // Timer 1 run
  output logic             timer0_overflow_flag_out, // Timer 0 flag
  output logic [T1_WIDTH-1:0] t1_count_out           // Timer 1 count
);
  // ==========================================================
  // Decode
  // The register sits on every page, so only the address is compared.
  // A byte write and a bit write may come in one cycle; the byte wins,
  // which keeps the write path free of any arbitration state.
  // Reads are registered so the CPU sees the value one cycle later.
  wire hit      = (sfr_addr_in == TIMER_CONTROL_ADDR);        // Register selected
  wire byte_wr  = hit & sfr_wr_in;                            // Whole-byte write
  wire bit_hit  = hit & bit_wr_in;                            // Bit write to register

  // Per-bit write request and value, shared by all three bits
  // Bits 4..0 belong to other logic and are neither stored nor driven
  function automatic logic wr_en(input int b);
    return byte_wr | (bit_hit & (bit_sel_in == b[2:0]));
  endfunction
  function automatic logic wr_val(input int b);
    return byte_wr ? sfr_wdata_in[b] : bit_val_in;
  endfunction

  logic        t1_flag_r, t1_run_r, t0_flag_r; // Slice state
  logic [7:0]  rdata_r;                        // Read data register
  logic        t1_ovf;                         // Overflow from Timer 1
  logic [T1_WIDTH-1:0] t1_count;               // Timer 1 count

  // ==========================================================
  // Next-state logic
  // Clear by vector or written zero; an overflow in the same cycle wins
  // Losing an overflow would drop an interrupt, so the set is never masked.
  // A vector beats a software write of one, so a handled event stays handled.
  wire t1_clr     = t1_vector_in | (wr_en(T1_FLAG_BIT) & ~wr_val(T1_FLAG_BIT));
  wire t0_clr     = t0_vector_in | (wr_en(T0_FLAG_BIT) & ~wr_val(T0_FLAG_BIT));
  wire t1_flag_nxt = t1_ovf | (t1_flag_r & ~t1_clr) |
                     (wr_en(T1_FLAG_BIT) & wr_val(T1_FLAG_BIT) & ~t1_vector_in);
  wire t0_flag_nxt = t0_ovf_in | (t0_flag_r & ~t0_clr) |
                     (wr_en(T0_FLAG_BIT) & wr_val(T0_FLAG_BIT) & ~t0_vector_in);
  wire t1_run_nxt  = wr_en(T1_RUN_BIT) ? wr_val(T1_RUN_BIT) : t1_run_r;
  wire [7:0] view  = {t1_flag_r, t1_run_r, t0_flag_r, 5'h00}; // Unowned bits read zero

  // ==========================================================
  // Register state
  // Reset takes constants only; each slice bit comes from the reset value, read data resets to 8'h00
  // Read data returns to zero when no read is pending
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      t1_flag_r <= TIMER_CONTROL_RESET[T1_FLAG_BIT];
      t1_run_r  <= TIMER_CONTROL_RESET[T1_RUN_BIT];
      t0_flag_r <= TIMER_CONTROL_RESET[T0_FLAG_BIT];
      rdata_r   <= 8'h00;
    end else begin
      t1_flag_r <= t1_flag_nxt;
      t1_run_r  <= t1_run_nxt;
      t0_flag_r <= t0_flag_nxt;
      rdata_r   <= (hit & sfr_rd_in) ? (view & SLICE_MASK) : 8'h00;
    end
  end

  // ==========================================================
  // Timer 1 counter, gated by the run bit
  // The run bit is taken from the flop, so a write starts counting a cycle later
  // Its wrap pulse is registered, so the flag lands two cycles after the tick
  timer1_counter #(.WIDTH(T1_WIDTH)) u_t1 (
    .sys_clk_in   (sys_clk_in),
    .rst_n_in     (rst_n_in),
    .run_in       (t1_run_r),
    .tick_in      (t1_tick_in),
    .count_out    (t1_count),
    .overflow_out (t1_ovf)
  );

  // ==========================================================
  // Outputs, each straight from a flop
  assign sfr_rdata_out            = rdata_r;
  assign timer1_overflow_flag_out = t1_flag_r;
  assign timer1_run_out           = t1_run_r;
  assign timer0_overflow_flag_out = t0_flag_r;
  assign t1_count_out             = t1_count;

  // ==========================================================
  // Checks
  // All checks run on the system clock and stay quiet in reset

  // Overflow pulse shows as a set flag one cycle later
  a_t1_flag_set: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    t1_ovf |=> t1_flag_r)
    else $error("Timer 1 flag not set on overflow");

  // Timer 1 flag moves only on overflow, vector or register write
  a_t1_flag_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    !t1_ovf && !t1_vector_in && !byte_wr && !bit_hit |=> $stable(t1_flag_r))
    else $error("Timer 1 flag changed with no cause");

  // Vector acknowledge clears the flag unless an overflow lands with it
  a_t1_vec_clear: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    t1_vector_in && !t1_ovf |=> !t1_flag_r)
    else $error("Timer 1 flag not cleared by vector");

  // Vector also beats a software write of one in the same cycle
  a_t1_vec_wins: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    t1_vector_in && !t1_ovf && byte_wr && sfr_wdata_in[T1_FLAG_BIT] |=> !t1_flag_r)
    else $error("Timer 1 write of one beat the vector");

  // Byte write of zero clears the Timer 1 flag
  a_t1_sw_clear: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    byte_wr && !sfr_wdata_in[T1_FLAG_BIT] && !t1_ovf |=> !t1_flag_r)
    else $error("Timer 1 flag not cleared by write");

  // Bit write of zero clears the Timer 1 flag
  a_t1_bit_clear: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    bit_hit && !byte_wr && bit_sel_in == 3'h7 && !bit_val_in && !t1_ovf |=> !t1_flag_r)
    else $error("Timer 1 flag not cleared by bit write");

  // Byte write loads the run bit
  a_t1_run_write: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    byte_wr |=> t1_run_r == $past(sfr_wdata_in[T1_RUN_BIT]))
    else $error("Timer 1 run not written");

  // Bit write loads the run bit when no byte write competes
  a_t1_bit_run: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    bit_hit && !byte_wr && bit_sel_in == 3'h6 |=> t1_run_r == $past(bit_val_in))
    else $error("Timer 1 run not written by bit write");

  // Run bit holds while no write reaches the register
  a_t1_run_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    !byte_wr && !bit_hit |=> $stable(t1_run_r))
    else $error("Timer 1 run changed with no write");

  // Timer 0 overflow sets its flag one cycle later
  a_t0_flag_set: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    t0_ovf_in |=> t0_flag_r)
    else $error("Timer 0 flag not set on overflow");

  // Timer 0 flag moves only on overflow, vector or register write
  a_t0_flag_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    !t0_ovf_in && !t0_vector_in && !byte_wr && !bit_hit |=> $stable(t0_flag_r))
    else $error("Timer 0 flag changed with no cause");

  // Vector acknowledge clears the Timer 0 flag
  a_t0_vec_clear: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    t0_vector_in && !t0_ovf_in |=> !t0_flag_r)
    else $error("Timer 0 flag not cleared by vector");

  // Byte write of zero clears the Timer 0 flag
  a_t0_sw_clear: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    byte_wr && !sfr_wdata_in[T0_FLAG_BIT] && !t0_ovf_in |=> !t0_flag_r)
    else $error("Timer 0 flag not cleared by write");

  // Bit write of zero clears the Timer 0 flag
  a_t0_bit_clear: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    bit_hit && !byte_wr && bit_sel_in == 3'h5 && !bit_val_in && !t0_ovf_in |=> !t0_flag_r)
    else $error("Timer 0 flag not cleared by bit write");

  // Two stopped cycles in a row leave the count untouched
  a_t1_stop_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    !t1_run_r [*2] |-> $stable(t1_count))
    else $error("Timer 1 count moved while stopped");

  // ==========================================================
  // Coverage of the main scenarios
  c_t1_overflow: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in) t1_ovf ##1 t1_flag_r);
  c_t0_vector:   cover property (@(posedge sys_clk_in) disable iff (!rst_n_in) t0_flag_r ##1 t0_vector_in);
  c_set_wins:    cover property (@(posedge sys_clk_in) disable iff (!rst_n_in) t0_ovf_in && t0_vector_in);
  c_run_bit:     cover property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    bit_hit && bit_sel_in == 3'h6 && bit_val_in ##1 t1_run_r);
endmodule

// *** cpu_bus_model.sv ***
`timescale 1ns/1ps
// ==========================================================
// CPU core stand-in: register access and vector pulses
module cpu_bus_model (
  input  wire logic       sys_clk_in,  // System clock
  output logic [7:0]      addr_out,    // Register address
  output logic            wr_out,      // Byte write strobe
  output logic            rd_out,      // Read strobe
  output logic [7:0]      wdata_out,   // Write data
  output logic            bit_wr_out,  // Bit write strobe
  output logic [2:0]      bit_sel_out, // Bit number
  output logic            bit_val_out, // Bit value
  output logic [1:0]      vec_out      // Vector pulses, Timer 1 high bit
);
  initial {addr_out, wr_out, rd_out, wdata_out, bit_wr_out, bit_sel_out, bit_val_out, vec_out} = '0;
  // One access; kind is {read, bit write, byte write}, bit value in d[7]
  // Idle bus shows inverted address and data so a stale address never matches
  task automatic access(input logic [7:0] a, input logic [2:0] kind, input logic [7:0] d);
    @(posedge sys_clk_in) #1;
    {rd_out, bit_wr_out, wr_out} = kind;
    addr_out = a;
    wdata_out = d;
    {bit_val_out, bit_sel_out} = {d[7], d[2:0]};
    @(posedge sys_clk_in) #1;
    {rd_out, bit_wr_out, wr_out} = 3'h0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask
  // One-cycle vector acknowledge
  task automatic vector(input logic [1:0] v);
    @(posedge sys_clk_in) #1;
    vec_out = v;
    @(posedge sys_clk_in) #1;
    vec_out = 2'h0;
  endtask
endmodule

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench import timer_ctl_pkg::*;;
  // ==========================================================
  // Signals
  logic sys_clk = 1'b0, rst_n = 1'b0, tick = 1'b0, t0_ovf = 1'b0; // Bench-driven inputs
  logic [7:0] addr, wdata, rdata;                // Register bus
  logic wr, rd, bwr, bval, t1f, run, t0f;        // Strobes and slice bits
  logic [2:0] bsel;                              // Bit number
  logic [1:0] vec;                               // Vector pulses
  logic [T1_WIDTH-1:0] count;                    // Timer 1 count
  int fails = 0, compares = 0;                   // Report counters
  always #12.5 sys_clk = ~sys_clk;               // 40 MHz
  cpu_bus_model cpu (.sys_clk_in(sys_clk), .addr_out(addr), .wr_out(wr), .rd_out(rd), .wdata_out(wdata),
    .bit_wr_out(bwr), .bit_sel_out(bsel), .bit_val_out(bval), .vec_out(vec));
  timer_overflow_run_control DUT (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .sfr_addr_in(addr), .sfr_wr_in(wr),
    .sfr_rd_in(rd), .sfr_wdata_in(wdata), .bit_wr_in(bwr), .bit_sel_in(bsel), .bit_val_in(bval),
    .t1_tick_in(tick), .t0_ovf_in(t0_ovf), .t1_vector_in(vec[1]), .t0_vector_in(vec[0]),
    .sfr_rdata_out(rdata), .timer1_overflow_flag_out(t1f), .timer1_run_out(run),
    .timer0_overflow_flag_out(t0f), .t1_count_out(count));
  // ==========================================================
  // Shared checks and helpers
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("Compares %0d, errors %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Read lands one cycle after the strobe, looked at in that cycle
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    cpu.access(a, 3'h4, 8'h00);
    chk("rdata", {8'h00, rdata}, {8'h00, exp});
  endtask
  // Tick held high for k edges advances a running count by k
  task automatic ticks(input int k);
    @(posedge sys_clk) #1 tick = 1'b1;
    repeat (k) @(posedge sys_clk);
    #1 tick = 1'b0;
  endtask
  // ==========================================================
  // Scenarios
  task automatic s_run();
    rd_chk(8'h88, TIMER_CONTROL_RESET);
    cpu.access(8'h88, 3'h1, 8'h40);
    chk("run", run, 1'b1);
    rd_chk(8'h89, 8'h00);
    ticks(10);
    chk("count", count, 16'h000a);
    cpu.access(8'h88, 3'h1, 8'h00);
    ticks(5);
    chk("count held", count, 16'h000a);
  endtask
  task automatic s_t0();
    @(posedge sys_clk) #1 t0_ovf = 1'b1;
    @(posedge sys_clk) #1 t0_ovf = 1'b0;
    rd_chk(8'h88, 8'h20);
    cpu.vector(2'h1);
    chk("t0 flag vec", t0f, 1'b0);
    @(posedge sys_clk) #1 t0_ovf = 1'b1;
    @(posedge sys_clk) #1 t0_ovf = 1'b0;
    cpu.access(8'h88, 3'h2, 8'h05);
    chk("t0 flag wr0", t0f, 1'b0);
  endtask
  task automatic s_t1();
    int n;
    cpu.access(8'h88, 3'h2, 8'h86);
    ticks(65525);
    chk("t1 flag early", t1f, 1'b0);
    ticks(1);
    for (n = 0; n < 4 && t1f !== 1'b1; n++) @(posedge sys_clk);
    if (n == 4) begin
      fails++;
      stop_test();
    end
    chk("wrap count", count, 16'h0000);
    cpu.vector(2'h2);
    chk("t1 flag vec", t1f, 1'b0);
    cpu.access(8'h88, 3'h2, 8'h87);
    cpu.access(8'h88, 3'h1, 8'h40);
    rd_chk(8'h88, 8'h40);
  endtask
  // ==========================================================
  // Main sequence: two-cycle reset, then each scenario
  initial begin
    repeat (2) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    s_run();
    s_t0();
    s_t1();
    stop_test();
  end
endmodule
